// ==== logic/rfi_interlock.sv ====
// Operation
// - all rods in needs both channels
// - channel true only if every contact closed
// - loaded, rods out, near core: stop travel
// - startup mode: near core stops travel
// - refuel mode: multiple rods out near core stops travel
// - frame hoist lift off when loaded, unsafe
// - trolley hoist lift off when loaded, unsafe
// - grapple inhibited when rods out near core
// - refuel mode rod block: load near core or second rod
// - startup mode: near core blocks rods
// - grapple not full up counts as loaded
// - open hoist load switch means loaded
// - open position switch means near core
// - main hoist load against three thresholds
// - two rod block outputs, power enables removed
// - two simultaneous selections never accepted
// - bypass plug ignores service platform hoist
`timescale 1ns/1ps
`default_nettype none
`include "rfi_regs.svh"
module rfi_interlock #(
   parameter int NRODS = 8,
   parameter int LW = 16,
   parameter int DEB_CYC = `RFI_DEB_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NRODS-1:0] rod_in_a,
   input wire logic [NRODS-1:0] rod_in_b,
   input wire logic [NRODS-1:0] rod_sel,
   input wire logic [1:0] pos_sw,
   input wire logic [2:0] hoist_sw,
   input wire logic grapple_up_sw,
   input wire logic svc_hoist_sw,
   input wire logic svc_bypass,
   input wire logic [1:0] mode_sw,
   input wire logic [LW-1:0] main_load,
   output logic travel_inhibit,
   output logic fmh_lift_en,
   output logic tmh_lift_en,
   output logic grapple_en,
   output logic hoist_lower_en,
   output logic rod_block_a,
   output logic rod_block_b,
   output logic irq
);
   localparam int NI = 3 * NRODS + 10;
   localparam int CW = $clog2(DEB_CYC + 1);
   localparam logic [CW-1:0] DEB_LAST = CW'(DEB_CYC - 1);

   function automatic logic more_than_one(input logic [NRODS-1:0] v);
      logic seen;
      logic many;
      seen = 1'b0;
      many = 1'b0;
      for (int i = 0; i < NRODS; i++) begin
         many = many | (seen & v[i]);
         seen = seen | v[i];
      end
      return many;
   endfunction

   // ****************************************
   // input conditioning
   // ****************************************
   logic [NI-1:0] raw;
   logic [NI-1:0] deb;
   assign raw = {mode_sw, svc_bypass, svc_hoist_sw, grapple_up_sw,
      hoist_sw, pos_sw, rod_sel, rod_in_b, rod_in_a};

   genvar gi;
   generate
      for (gi = 0; gi < NI; gi++) begin : g_deb
         logic s1_r;
         logic s2_r;
         logic st_r;
         logic [CW-1:0] cnt_r;
         // open contact is the reset state
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
            end else begin
               s1_r <= raw[gi];
               s2_r <= s1_r;
            end
         end
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               st_r <= 1'b0;
               cnt_r <= '0;
            end else if (s2_r == st_r) begin
               cnt_r <= '0;
            end else if (cnt_r >= DEB_LAST) begin
               st_r <= s2_r;
               cnt_r <= '0;
            end else begin
               cnt_r <= cnt_r + CW'(1);
            end
         end
         assign deb[gi] = st_r;
      end
   endgenerate

   // word taken only when two synced samples agree
   logic [LW-1:0] load_s1_r;
   logic [LW-1:0] load_s2_r;
   logic [LW-1:0] load_s3_r;
   logic [LW-1:0] load_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_s1_r <= '0;
         load_s2_r <= '0;
         load_s3_r <= '0;
         load_r <= '0;
      end else begin
         load_s1_r <= main_load;
         load_s2_r <= load_s1_r;
         load_s3_r <= load_s2_r;
         if (load_s2_r == load_s3_r) begin
            load_r <= load_s3_r;
         end
      end
   end

   // ****************************************
   // sensed conditions
   // ****************************************
   logic [NRODS-1:0] ins_a;
   logic [NRODS-1:0] ins_b;
   logic [NRODS-1:0] sel;
   logic [NRODS-1:0] wdrawn;
   logic [1:0] pos;
   logic [2:0] hsw;
   logic fullup;
   logic svc_sw;
   logic bypass;
   rfi_pkg::rfi_mode_t mode;
   logic startup;
   logic refuel;
   logic all_in;
   logic near;
   logic fmh_ld;
   logic tmh_ld;
   logic fg_ld;
   logic svc_ld;
   logic any_ld;
   logic multi_wd;
   logic multi_sel;
   logic other_wd;
   logic jam;
   logic slack;
   logic [LW-1:0] th_loaded_r;
   logic [LW-1:0] th_jam_r;
   logic [LW-1:0] th_slack_r;

   assign ins_a = deb[NRODS-1:0];
   assign ins_b = deb[2*NRODS-1:NRODS];
   assign sel = deb[3*NRODS-1:2*NRODS];
   assign pos = deb[3*NRODS+1:3*NRODS];
   assign hsw = deb[3*NRODS+4:3*NRODS+2];
   assign fullup = deb[3*NRODS+5];
   assign svc_sw = deb[3*NRODS+6];
   assign bypass = deb[3*NRODS+7];
   assign mode = rfi_pkg::rfi_mode_t'(deb[3*NRODS+9:3*NRODS+8]);
   // an illegal mode code applies both restrictions
   assign startup = (mode == rfi_pkg::RFI_MODE_STARTUP) |
      (mode == rfi_pkg::RFI_MODE_BAD);
   assign refuel = (mode == rfi_pkg::RFI_MODE_REFUEL) |
      (mode == rfi_pkg::RFI_MODE_BAD);
   assign all_in = (&ins_a) & (&ins_b);
   assign wdrawn = ~(ins_a & ins_b);
   assign near = ~pos[0] | ~pos[1];
   assign jam = load_r >= th_jam_r;
   assign slack = load_r <= th_slack_r;
   assign fmh_ld = ~hsw[0] | (load_r >= th_loaded_r);
   assign tmh_ld = ~hsw[1];
   assign fg_ld = ~hsw[2] | ~fullup;
   assign svc_ld = ~bypass & ~svc_sw;
   assign any_ld = fmh_ld | tmh_ld | fg_ld | svc_ld;
   assign multi_wd = more_than_one(wdrawn);
   assign multi_sel = more_than_one(sel);
   assign other_wd = (|sel) & (|(wdrawn & ~sel));

   // ****************************************
   // interlock outputs
   // ****************************************
   logic travel_nxt;
   logic block_nxt;
   assign travel_nxt = (any_ld & ~all_in & near) |
      (startup & near) |
      (refuel & multi_wd & near);
   assign block_nxt = multi_sel |
      (refuel & ((near & any_ld) | other_wd)) |
      (startup & near);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         travel_inhibit <= 1'b1;
         fmh_lift_en <= 1'b0;
         tmh_lift_en <= 1'b0;
         grapple_en <= 1'b0;
         hoist_lower_en <= 1'b0;
      end else begin
         travel_inhibit <= travel_nxt;
         fmh_lift_en <= ~(fmh_ld & ~all_in & near) & ~jam;
         tmh_lift_en <= ~(tmh_ld & ~all_in & near);
         grapple_en <= ~(~all_in & near);
         hoist_lower_en <= ~slack;
      end
   end

   // two separate contacts in the block circuit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rod_block_a <= 1'b1;
      end else begin
         rod_block_a <= block_nxt;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rod_block_b <= 1'b1;
      end else begin
         rod_block_b <= block_nxt;
      end
   end

   // ****************************************
   // events and interrupt
   // ****************************************
   logic [`RFI_IRQ_W-1:0] ev;
   logic [`RFI_IRQ_W-1:0] ev_lvl_r;
   logic [`RFI_IRQ_W-1:0] ev_lvl;
   logic [`RFI_IRQ_W-1:0] istat_r;
   logic [`RFI_IRQ_W-1:0] imask_r;
   logic [`RFI_IRQ_W-1:0] w1c;
   logic wr_acc;
   logic rd_setup;
   logic [31:0] rdata;
   logic hit;

   assign ev_lvl = {multi_sel, ~hoist_lower_en, jam, rod_block_a,
      travel_inhibit};
   assign ev = ev_lvl & ~ev_lvl_r;
   assign wr_acc = psel & penable & pwrite & pready;
   assign w1c = (wr_acc && paddr == `RFI_OFS_ISTAT) ?
      pwdata[`RFI_IRQ_W-1:0] : '0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_lvl_r <= '1;
      end else begin
         ev_lvl_r <= ev_lvl;
      end
   end
   // a new event wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat_r <= '0;
      end else begin
         istat_r <= (istat_r & ~w1c) | ev;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(istat_r & imask_r);
      end
   end

   // ****************************************
   // apb slave
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         th_loaded_r <= LW'(`RFI_RST_LOADED);
         th_jam_r <= LW'(`RFI_RST_JAM);
         th_slack_r <= LW'(`RFI_RST_SLACK);
         imask_r <= `RFI_RST_IMASK;
      end else if (wr_acc) begin
         unique case (paddr)
            `RFI_OFS_LOADED: th_loaded_r <= pwdata[LW-1:0];
            `RFI_OFS_JAM: th_jam_r <= pwdata[LW-1:0];
            `RFI_OFS_SLACK: th_slack_r <= pwdata[LW-1:0];
            `RFI_OFS_IMASK: imask_r <= pwdata[`RFI_IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   assign rd_setup = psel & ~penable;
   always_comb begin
      rdata = '0;
      hit = 1'b1;
      unique case (paddr)
         `RFI_OFS_LOADED: rdata[LW-1:0] = th_loaded_r;
         `RFI_OFS_JAM: rdata[LW-1:0] = th_jam_r;
         `RFI_OFS_SLACK: rdata[LW-1:0] = th_slack_r;
         `RFI_OFS_STATE: rdata[7:0] = {near, all_in, hoist_lower_en,
            rod_block_a, grapple_en, tmh_lift_en, fmh_lift_en,
            travel_inhibit};
         `RFI_OFS_ISTAT: rdata[`RFI_IRQ_W-1:0] = istat_r;
         `RFI_OFS_IMASK: rdata[`RFI_IRQ_W-1:0] = imask_r;
         `RFI_OFS_LOAD: rdata[LW-1:0] = load_r;
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= rd_setup;
         pslverr <= rd_setup & ~hit;
         if (rd_setup && !pwrite) begin
            prdata <= rdata;
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_rods_out_near;
      !all_in && near;
   endsequence
   sequence s_fmh_unsafe;
      fmh_ld ##0 s_rods_out_near;
   endsequence

   a_air_both_chan: assert property (
      (!(&ins_a) || !(&ins_b)) |-> !all_in)
      else $error("all rods in with a channel open");
   a_travel_loaded: assert property (
      (any_ld and s_rods_out_near) |=> travel_inhibit)
      else $error("loaded travel not inhibited");
   a_travel_startup: assert property (
      (startup && near) |=> travel_inhibit)
      else $error("startup travel not inhibited");
   a_travel_refuel: assert property (
      (refuel && multi_wd && near) |=> travel_inhibit)
      else $error("refuel travel not inhibited");
   a_fmh_lift_off: assert property (
      s_fmh_unsafe |=> !fmh_lift_en)
      else $error("frame hoist lift enabled");
   a_tmh_lift_off: assert property (
      (tmh_ld && !all_in && near) |=> !tmh_lift_en)
      else $error("trolley hoist lift enabled");
   a_grapple_stop: assert property (
      s_rods_out_near |=> !grapple_en)
      else $error("grapple enabled near core");
   a_block_second: assert property (
      (refuel && other_wd) |=> rod_block_a && rod_block_b)
      else $error("second rod not blocked");
   a_block_startup: assert property (
      (startup && near) |=> rod_block_a && rod_block_b)
      else $error("startup near core not blocked");
   a_block_pair: assert property (
      rod_block_a == rod_block_b)
      else $error("rod block outputs disagree");
   a_multi_select: assert property (
      multi_sel |=> rod_block_a && rod_block_b &&
         (istat_r[`RFI_IRQ_MULTI] || $past(ev_lvl_r[`RFI_IRQ_MULTI])))
      else $error("double selection accepted");
   a_svc_bypass: assert property (
      bypass |-> !svc_ld)
      else $error("service hoist seen under bypass");
   a_grapple_load: assert property (
      !fullup |-> fg_ld && any_ld)
      else $error("grapple down not loaded");
endmodule // rfi_interlock
`default_nettype wire

// ==== logic/rfi_regs.svh ====
`ifndef RFI_REGS_SVH
`define RFI_REGS_SVH
// ****************************************
// register offsets
// ****************************************
`define RFI_OFS_LOADED 12'h000
`define RFI_OFS_JAM 12'h004
`define RFI_OFS_SLACK 12'h008
`define RFI_OFS_STATE 12'h00C
`define RFI_OFS_ISTAT 12'h010
`define RFI_OFS_IMASK 12'h014
`define RFI_OFS_LOAD 12'h018
// ****************************************
// reset values
// ****************************************
`define RFI_RST_LOADED 16'h0100
`define RFI_RST_JAM 16'h0F00
`define RFI_RST_SLACK 16'h0010
`define RFI_RST_IMASK 5'h00
// ****************************************
// state register fields
// ****************************************
`define RFI_ST_TRAVEL 0
`define RFI_ST_FMH 1
`define RFI_ST_TMH 2
`define RFI_ST_GRAPPLE 3
`define RFI_ST_BLOCK 4
`define RFI_ST_LOWER 5
`define RFI_ST_ALLIN 6
`define RFI_ST_NEAR 7
// ****************************************
// interrupt status fields
// ****************************************
`define RFI_IRQ_TRAVEL 0
`define RFI_IRQ_BLOCK 1
`define RFI_IRQ_JAM 2
`define RFI_IRQ_SLACK 3
`define RFI_IRQ_MULTI 4
`define RFI_IRQ_W 5
// ****************************************
// timing
// ****************************************
`define RFI_CLK_MHZ 200
`define RFI_DEB_TIME_US 5000
`define RFI_DEB_CYC (`RFI_DEB_TIME_US * `RFI_CLK_MHZ)
`endif

// ==== logic/rfi_pkg.sv ====
`default_nettype none
package rfi_pkg;
   // ****************************************
   // mode switch positions
   // ****************************************
   typedef enum logic [1:0] {
      RFI_MODE_RUN = 2'h0,
      RFI_MODE_STARTUP = 2'h1,
      RFI_MODE_REFUEL = 2'h2,
      RFI_MODE_BAD = 2'h3
   } rfi_mode_t;
endpackage
`default_nettype wire

// ==== tb/rfi_plant.sv ====
`timescale 1ns/1ps
`default_nettype none
// ********
// plant switch model, 1 = closed contact
// ********
module rfi_plant #(
   parameter int NRODS = 8
) (
   input wire logic [1:0] pos_open,
   input wire logic [NRODS-1:0] rods_out,
   input wire logic [NRODS-1:0] b_extra,
   input wire logic [2:0] loaded,
   input wire logic grapple_down,
   input wire logic svc_loaded,
   output logic [NRODS-1:0] rod_in_a,
   output logic [NRODS-1:0] rod_in_b,
   output logic [1:0] pos_sw,
   output logic [2:0] hoist_sw,
   output logic grapple_up_sw,
   output logic svc_hoist_sw
);
   always_comb begin
      rod_in_a = ~rods_out;
      rod_in_b = ~(rods_out | b_extra);
      pos_sw = ~pos_open;
      hoist_sw = ~loaded;
      grapple_up_sw = ~grapple_down;
      svc_hoist_sw = ~svc_loaded;
   end
endmodule // rfi_plant
`default_nettype wire

// ==== tb/refuel_interlock_logic_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rfi_regs.svh"
module refuel_interlock_logic_test;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, irq;
   logic travel_inhibit, fmh_lift_en, tmh_lift_en, grapple_en;
   logic hoist_lower_en, rod_block_a, rod_block_b;
   logic [7:0] rod_in_a, rod_in_b;
   logic [7:0] rod_sel = 8'h00;
   logic [7:0] rods_out = 8'h00;
   logic [7:0] b_extra = 8'h00;
   logic [1:0] pos_open = 2'h0;
   logic [1:0] pos_sw;
   logic [2:0] loaded = 3'h0;
   logic [2:0] hoist_sw;
   logic grapple_down = 1'b0;
   logic svc_loaded = 1'b0;
   logic svc_bypass = 1'b0;
   logic grapple_up_sw, svc_hoist_sw;
   logic [1:0] mode_sw = 2'h0;
   logic [15:0] main_load = 16'h0040;
   logic [31:0] rd;
   logic er;
   int bad_count = 0;
   int checked = 0;
   integer seed = 32'h2d364efb;
   always #2.5 pclk = ~pclk;
   rfi_plant #(.NRODS(8)) plant (.pos_open(pos_open), .rods_out(rods_out),
      .b_extra(b_extra), .loaded(loaded), .grapple_down(grapple_down),
      .svc_loaded(svc_loaded), .rod_in_a(rod_in_a), .rod_in_b(rod_in_b),
      .pos_sw(pos_sw), .hoist_sw(hoist_sw), .grapple_up_sw(grapple_up_sw),
      .svc_hoist_sw(svc_hoist_sw));
   rfi_interlock #(.NRODS(8), .LW(16), .DEB_CYC(4)) DUT (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rod_in_a(rod_in_a), .rod_in_b(rod_in_b),
      .rod_sel(rod_sel), .pos_sw(pos_sw), .hoist_sw(hoist_sw),
      .grapple_up_sw(grapple_up_sw), .svc_hoist_sw(svc_hoist_sw),
      .svc_bypass(svc_bypass), .mode_sw(mode_sw), .main_load(main_load),
      .travel_inhibit(travel_inhibit), .fmh_lift_en(fmh_lift_en),
      .tmh_lift_en(tmh_lift_en), .grapple_en(grapple_en),
      .hoist_lower_en(hoist_lower_en), .rod_block_a(rod_block_a),
      .rod_block_b(rod_block_b), .irq(irq));
   // ********
   // tasks
   // ********
   task automatic report_and_stop();
      if (bad_count == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex,
                      input logic [31:0] got);
      checked++;
      if (got !== ex) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [7:0] model();
      logic [7:0] wd;
      logic al, nr, ld, su, rf, bk, tr, lf, lj, ls;
      wd = rods_out | b_extra;
      al = (wd == 8'h00);
      nr = |pos_open;
      lf = main_load >= `RFI_RST_LOADED;
      lj = main_load >= `RFI_RST_JAM;
      ls = main_load <= `RFI_RST_SLACK;
      ld = |loaded | lf | grapple_down | (svc_loaded & ~svc_bypass);
      su = mode_sw[0];
      rf = mode_sw[1];
      bk = (rf & nr & ld) | (rf & |rod_sel & |(wd & ~rod_sel));
      bk = bk | (su & nr) | ($countones(rod_sel) > 1);
      tr = nr & ((ld & ~al) | su | (rf & ($countones(wd) > 1)));
      return {nr, al, ~ls, bk, ~(~al & nr), ~(loaded[1] & ~al & nr),
              ~((loaded[0] | lf) & ~al & nr) & ~lj, tr};
   endfunction
   task automatic check_all();
      logic [7:0] e;
      e = model();
      chk("outputs", {25'h0, e[5], e[4], e[4:0]}, {25'h0, hoist_lower_en,
          rod_block_b, rod_block_a, grapple_en, tmh_lift_en, fmh_lift_en,
          travel_inhibit});
      apb(1'b0, `RFI_OFS_STATE, 32'h0);
      chk("state", {24'h0, e}, rd);
   endtask
   task automatic shuffle();
      logic [31:0] r;
      r = $random(seed);
      mode_sw <= r[1:0];
      pos_open <= r[3:2];
      loaded <= r[6:4] & {3{r[7]}};
      grapple_down <= r[8] & r[9];
      svc_loaded <= r[10];
      svc_bypass <= r[11];
      rods_out <= r[12] ? 8'h00 : (r[13] ? 8'h01 << r[16:14] : r[24:17]);
      b_extra <= (r[25] & r[26]) ? 8'h80 : 8'h00;
      rod_sel <= r[27] ? 8'h00 : (r[28] ? 8'h01 << r[31:29] : 8'h81);
      main_load <= 16'h0020 + {9'h000, r[22:16]};
   endtask
   // ********
   // sequence
   // ********
   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      report_and_stop();
   end
   initial begin
      int i;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (12) @(posedge pclk);
      apb(1'b0, `RFI_OFS_LOADED, 32'h0);
      chk("loaded_th", 32'h00000100, rd);
      apb(1'b0, `RFI_OFS_JAM, 32'h0);
      chk("jam_th", 32'h00000F00, rd);
      apb(1'b0, `RFI_OFS_SLACK, 32'h0);
      chk("slack_th", 32'h00000010, rd);
      apb(1'b0, `RFI_OFS_IMASK, 32'h0);
      chk("imask", 32'h00000000, rd);
      apb(1'b0, 12'h01C, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, er});
      chk("unmapped_data", 32'h0, rd);
      for (i = 0; i < 40; i++) begin
         @(posedge pclk);
         shuffle();
         repeat (12) @(posedge pclk);
         check_all();
      end
      @(posedge pclk);
      {mode_sw, pos_open, loaded, grapple_down, svc_loaded} <= 9'h000;
      rods_out <= 8'h01;
      b_extra <= 8'h00;
      rod_sel <= 8'h00;
      repeat (12) @(posedge pclk);
      check_all();
      pos_open <= 2'h1;
      repeat (2) @(posedge pclk);
      pos_open <= 2'h0;
      for (i = 0; i < 12; i++) begin
         @(posedge pclk);
         chk("glitch", 32'h1, {31'h0, grapple_en});
      end
      apb(1'b1, `RFI_OFS_ISTAT, 32'h0000001F);
      @(posedge pclk);
      mode_sw <= 2'h1;
      pos_open <= 2'h2;
      repeat (12) @(posedge pclk);
      check_all();
      chk("irq_masked", 32'h0, {31'h0, irq});
      apb(1'b0, `RFI_OFS_ISTAT, 32'h0);
      chk("istat", 32'h3, rd);
      apb(1'b1, `RFI_OFS_IMASK, 32'h1);
      repeat (2) @(posedge pclk);
      chk("irq_on", 32'h1, {31'h0, irq});
      apb(1'b1, `RFI_OFS_ISTAT, 32'h1);
      repeat (2) @(posedge pclk);
      chk("irq_off", 32'h0, {31'h0, irq});
      apb(1'b0, `RFI_OFS_ISTAT, 32'h0);
      chk("istat_left", 32'h2, rd);
      main_load <= 16'h0F00;
      repeat (12) @(posedge pclk);
      check_all();
      main_load <= 16'h0010;
      repeat (12) @(posedge pclk);
      check_all();
      apb(1'b0, `RFI_OFS_LOAD, 32'h0);
      chk("load", 32'h00000010, rd);
      apb(1'b0, `RFI_OFS_ISTAT, 32'h0);
      chk("istat_load", 32'h0000000E, rd);
      report_and_stop();
   end
endmodule // refuel_interlock_logic_test
`default_nettype wire
